// file: rtl/pbg_pkg.sv
// Purpose: shared constants, types and helpers of the peripheral bus gateway
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes:   unit index order is usb, uart1, gen clock, ir uart, hs ir, uart3, codec, sync serial, pins
//
// Contract
// - bridge system bus to handshake peripheral bus
// - decode and gate programmed register accesses
// - only aligned 32-bit word accesses pass
// - registers sit in low bits, rest zero
// - widths 8, 16 or 32 per unit
// - burst sizes 4 words, 4 or 8 bytes
// - one 64 Kbyte region per unit
// - bases at 8000_0000 upward, 9006_0000, b010_0000
// - each engine has its own select; ir uart and hs ir share pending bit 16
// - pin controller takes no DMA requests
// - 32-bit pending vector of unmasked interrupts
// - pending bits 12, 13, 15, 16, 17, 18, 19
// - only serial port four gives two numbers
// - general clock engine raises no interrupt
// - display controller traffic bypasses the gateway

package pbg_pkg;

	localparam int NUM_UNITS = 9;

	// unit indices
	localparam logic [3:0] U_USB_DEV  = 4'h0;
	localparam logic [3:0] U_UART1    = 4'h1;
	localparam logic [3:0] U_GEN_CLK  = 4'h2;
	localparam logic [3:0] U_IR_UART  = 4'h3;
	localparam logic [3:0] U_HS_IR    = 4'h4;
	localparam logic [3:0] U_UART3    = 4'h5;
	localparam logic [3:0] U_CODEC    = 4'h6;
	localparam logic [3:0] U_SYNC_SER = 4'h7;
	localparam logic [3:0] U_PIN_CTRL = 4'h8;

	// upper address half of each 64 Kbyte unit region
	localparam logic [15:0] UNIT_BASE_HI [NUM_UNITS] = '{16'h8000, 16'h8001, 16'h8002, 16'h8003,
		16'h8004, 16'h8005, 16'h8006, 16'h8007, 16'h9006};
	localparam logic [15:0] DISPLAY_BASE_HI = 16'hb010;

	// register width and DMA port size in bits
	localparam logic [5:0] UNIT_WIDTH_BITS [NUM_UNITS] = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h08,
		6'h08, 6'h10, 6'h10, 6'h20};
	// DMA burst in bytes, zero where the unit takes no DMA
	localparam logic [3:0] UNIT_BURST_BYTES [NUM_UNITS] = '{4'h8, 4'h4, 4'h0, 4'h4, 4'h8,
		4'h4, 4'h8, 4'h8, 4'h0};
	localparam logic [3:0] DISPLAY_BURST_WORDS = 4'h4; // display runs its own DMA

	localparam logic [1:0]  SIZE_WORD      = 2'h2;
	localparam logic [15:0] REG_SPAN_BYTES = 16'h0100;

	// interrupt pending bit numbers
	localparam int IRQ_DISPLAY  = 12;
	localparam int IRQ_USB_DEV  = 13;
	localparam int IRQ_UART1    = 15;
	localparam int IRQ_IR_PORT  = 16;
	localparam int IRQ_UART3    = 17;
	localparam int IRQ_CODEC    = 18;
	localparam int IRQ_SYNC_SER = 19;

	typedef enum logic [1:0] {PBG_IDLE, PBG_REQ, PBG_REL} pbg_state_type;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pbg_sys_req_type;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  unit;
		logic [15:0] offset;
	} pbg_dma_req_type;

	typedef struct packed {
		logic        req;
		logic        write;
		logic [8:0]  sel;
		logic [15:0] addr;
		logic [31:0] wdata;
	} pbg_pb_out_type;

	typedef struct packed {
		logic display;
		logic usb_dev;
		logic uart1;
		logic ir_uart;
		logic hs_ir;
		logic uart3;
		logic codec;
		logic sync_ser;
	} pbg_irq_src_type;

	// {hit, index} for an upper address half
	function automatic logic [4:0] unit_decode(input logic [15:0] hi);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < NUM_UNITS; i++) begin
			if (hi == UNIT_BASE_HI[i]) r = {1'b1, 4'(i)};
		end
		return r;
	endfunction

	// low-bit mask of a unit's register width
	function automatic logic [31:0] width_mask(input logic [3:0] u);
		logic [31:0] m;
		m = 32'h0;
		if (u < 4'(NUM_UNITS)) begin
			m = (UNIT_WIDTH_BITS[u] == 6'h20) ? 32'hffffffff : ((32'h1 << UNIT_WIDTH_BITS[u]) - 32'h1);
		end
		return m;
	endfunction

	// beats per DMA burst, zero where DMA is refused
	function automatic logic [3:0] burst_beats(input logic [3:0] u);
		logic [3:0] wb;
		wb = 4'h1;
		if (u >= 4'(NUM_UNITS)) return 4'h0;
		wb = 4'(UNIT_WIDTH_BITS[u] >> 3);
		return UNIT_BURST_BYTES[u] / wb;
	endfunction

endpackage

// file: rtl/pbg_irq_map.sv
// Purpose: maps unit interrupt lines onto pending bit numbers
// Assumes: lines are levels synchronous to clk
// Notes:   pending shows a line one cycle after it rises, gated by the mask
`timescale 1ns/1ps
`default_nettype none

module pbg_irq_map #(
	parameter int UART1_BIT = pbg_pkg::IRQ_UART1
) (
	input  wire logic                     clk,
	input  wire logic                     rstn,
	input  wire pbg_pkg::pbg_irq_src_type src,
	input  wire logic [31:0]              mask,
	output logic [31:0]                   pending
);

	typedef struct packed {
		logic [31:0] pending;
	} pbg_irq_st_type;

	pbg_irq_st_type st_r;
	pbg_irq_st_type st_nxt;
	logic [31:0]    raw;

	initial begin
		if (UART1_BIT < 0 || UART1_BIT > 31 || UART1_BIT == pbg_pkg::IRQ_USB_DEV ||
			UART1_BIT == pbg_pkg::IRQ_DISPLAY || (UART1_BIT >= pbg_pkg::IRQ_IR_PORT &&
			UART1_BIT <= pbg_pkg::IRQ_SYNC_SER)) $error("pbg_irq_map: bad UART1_BIT");
	end

	// line to bit placement; gen clock engine has no line at all
	always_comb begin
		raw = 32'h0;
		raw[pbg_pkg::IRQ_DISPLAY]  = src.display;
		raw[pbg_pkg::IRQ_USB_DEV]  = src.usb_dev;
		raw[UART1_BIT]             = src.uart1;
		raw[pbg_pkg::IRQ_IR_PORT]  = src.ir_uart | src.hs_ir;
		raw[pbg_pkg::IRQ_UART3]    = src.uart3;
		raw[pbg_pkg::IRQ_CODEC]    = src.codec;
		raw[pbg_pkg::IRQ_SYNC_SER] = src.sync_ser;
		st_nxt.pending = raw & mask;
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rstn) st_r <= '0;
		else st_r <= st_nxt;
	end

	assign pending = st_r.pending;

	pend_usb_a: assert property (@(posedge clk) disable iff (!rstn)
		src.usb_dev && mask[13] |=> pending[13]) else $error("usb line not on bit 13");
	pend_ir_a: assert property (@(posedge clk) disable iff (!rstn)
		(src.ir_uart || src.hs_ir) && mask[16] |=> pending[16]) else $error("ir line not on bit 16");
	pend_port4_a: assert property (@(posedge clk) disable iff (!rstn)
		src.codec && !src.sync_ser && (&mask) |=> pending[18] && !pending[19])
		else $error("codec and sync serial not separate");
	pend_mask_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> (pending & ~$past(mask)) == 32'h0) else $error("masked line shows pending");

endmodule // pbg_irq_map

`default_nettype wire

// file: rtl/pbg_gateway.sv
// Purpose: system bus to peripheral bus gateway with unit decode, DMA bursts and irq map
// Assumes: all inputs synchronous to clk; peripheral holds ack until req drops
// Notes:   one transfer at a time; programmed access wins over DMA in the same cycle
`timescale 1ns/1ps
`default_nettype none

module pbg_gateway #(
	parameter logic [15:0] REG_SPAN  = pbg_pkg::REG_SPAN_BYTES,
	parameter int          UART1_BIT = pbg_pkg::IRQ_UART1
) (
	input  wire logic                     clk,
	input  wire logic                     rstn,
	input  wire pbg_pkg::pbg_sys_req_type sys_req,
	output logic                          sys_accept,
	output logic                          sys_resp,
	output logic                          sys_err,
	output logic [31:0]                   sys_rdata,
	input  wire pbg_pkg::pbg_dma_req_type dma_req,
	input  wire logic [31:0]              dma_wdata,
	output logic                          dma_accept,
	output logic                          dma_data_take,
	output logic                          dma_beat_done,
	output logic                          dma_done,
	output logic                          dma_err,
	output logic [31:0]                   dma_rdata,
	output pbg_pkg::pbg_pb_out_type       pb,
	input  wire logic                     pb_ack,
	input  wire logic [31:0]              pb_rdata,
	input  wire pbg_pkg::pbg_irq_src_type irq_src,
	input  wire logic [31:0]              irq_mask,
	output logic [31:0]                   irq_pending
);

	typedef struct packed {
		pbg_pkg::pbg_state_type state;
		logic                   from_dma;
		logic [3:0]             unit;
		logic [3:0]             beats;
		pbg_pkg::pbg_pb_out_type pb;
		logic [31:0]            rdata;
		logic                   resp;
		logic                   err;
		logic                   beat_done;
		logic                   done;
	} pbg_ctl_type;

	pbg_ctl_type st_r;
	pbg_ctl_type st_nxt;
	logic [4:0]  dec;
	logic        sys_take;
	logic        dma_take;
	logic        sys_bad;
	logic        dma_bad;
	logic [3:0]  dma_beats;

	initial begin
		if (REG_SPAN == 16'h0 || REG_SPAN[1:0] != 2'h0) $error("pbg_gateway: bad REG_SPAN");
	end

	// decode and take; display and foreign addresses are never claimed
	always_comb begin
		dec       = pbg_pkg::unit_decode(sys_req.addr[31:16]);
		sys_take  = st_r.state == pbg_pkg::PBG_IDLE && sys_req.valid && dec[4];
		dma_take  = st_r.state == pbg_pkg::PBG_IDLE && !sys_take && dma_req.valid;
		sys_bad   = sys_req.size != pbg_pkg::SIZE_WORD || sys_req.addr[1:0] != 2'h0;
		dma_beats = pbg_pkg::burst_beats(dma_req.unit);
		dma_bad   = dma_beats == 4'h0 || dma_req.unit == pbg_pkg::U_PIN_CTRL ||
			dma_req.offset >= REG_SPAN || dma_req.offset[1:0] != 2'h0;
	end

	// next-state logic of the transfer engine
	always_comb begin
		st_nxt           = st_r;
		st_nxt.resp      = 1'b0;
		st_nxt.beat_done = 1'b0;
		st_nxt.done      = 1'b0;
		dma_data_take    = 1'b0;
		case (st_r.state)
			pbg_pkg::PBG_IDLE: begin
				if (sys_take) begin
					st_nxt.from_dma = 1'b0;
					st_nxt.unit     = dec[3:0];
					st_nxt.err      = 1'b0;
					st_nxt.rdata    = 32'h0;
					if (sys_bad) begin
						st_nxt.resp = 1'b1;
						st_nxt.err  = 1'b1;
					end else if (sys_req.addr[15:0] >= REG_SPAN) begin
						st_nxt.resp = 1'b1; // hole: zero, no strobe
					end else begin
						st_nxt.state    = pbg_pkg::PBG_REQ;
						st_nxt.pb.req   = 1'b1;
						st_nxt.pb.write = sys_req.write;
						st_nxt.pb.sel   = 9'h001 << dec[3:0];
						st_nxt.pb.addr  = sys_req.addr[15:0];
						st_nxt.pb.wdata = sys_req.wdata & pbg_pkg::width_mask(dec[3:0]);
					end
				end else if (dma_take) begin
					st_nxt.from_dma = 1'b1;
					st_nxt.unit     = dma_req.unit;
					st_nxt.err      = 1'b0;
					st_nxt.rdata    = 32'h0;
					if (dma_bad) begin
						st_nxt.done = 1'b1;
						st_nxt.err  = 1'b1;
					end else begin
						dma_data_take   = 1'b1;
						st_nxt.state    = pbg_pkg::PBG_REQ;
						st_nxt.beats    = dma_beats;
						st_nxt.pb.req   = 1'b1;
						st_nxt.pb.write = dma_req.write;
						st_nxt.pb.sel   = 9'h001 << dma_req.unit;
						st_nxt.pb.addr  = dma_req.offset;
						st_nxt.pb.wdata = dma_wdata & pbg_pkg::width_mask(dma_req.unit);
					end
				end
			end
			pbg_pkg::PBG_REQ: begin
				// wait for ack, capture read data in low bits
				if (pb_ack) begin
					st_nxt.pb.req = 1'b0;
					st_nxt.state  = pbg_pkg::PBG_REL;
					st_nxt.rdata  = st_r.pb.write ? 32'h0 : (pb_rdata & pbg_pkg::width_mask(st_r.unit));
				end
			end
			pbg_pkg::PBG_REL: begin
				// wait for ack release, then answer or run next beat
				if (!pb_ack) begin
					if (st_r.from_dma) begin
						st_nxt.beat_done = 1'b1;
						if (st_r.beats > 4'h1) begin
							dma_data_take   = 1'b1;
							st_nxt.beats    = st_r.beats - 4'h1;
							st_nxt.pb.req   = 1'b1;
							st_nxt.pb.wdata = dma_wdata & pbg_pkg::width_mask(st_r.unit);
							st_nxt.state    = pbg_pkg::PBG_REQ;
						end else begin
							st_nxt.done  = 1'b1;
							st_nxt.beats = 4'h0;
							st_nxt.state = pbg_pkg::PBG_IDLE;
						end
					end else begin
						st_nxt.resp  = 1'b1;
						st_nxt.state = pbg_pkg::PBG_IDLE;
					end
				end
			end
			default: begin
				st_nxt.state  = pbg_pkg::PBG_IDLE;
				st_nxt.pb.req = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rstn) st_r <= '0;
		else st_r <= st_nxt;
	end

	// outputs
	assign sys_accept    = sys_take;
	assign dma_accept    = dma_take;
	assign sys_resp      = st_r.resp;
	assign sys_err       = st_r.err & ~st_r.from_dma;
	assign sys_rdata     = st_r.rdata;
	assign dma_beat_done = st_r.beat_done;
	assign dma_done      = st_r.done;
	assign dma_err       = st_r.err & st_r.from_dma;
	assign dma_rdata     = st_r.rdata;
	assign pb            = st_r.pb;

	// interrupt line to pending bit map
	pbg_irq_map #(
		.UART1_BIT (UART1_BIT)
	) u_irq (
		.clk     (clk),
		.rstn    (rstn),
		.src     (irq_src),
		.mask    (irq_mask),
		.pending (irq_pending)
	);

	word_only_a: assert property (@(posedge clk) disable iff (!rstn)
		sys_take && sys_bad |=> sys_resp && sys_err && !pb.req) else $error("narrow access not refused");
	hole_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		sys_take && !sys_bad && sys_req.addr[15:0] >= REG_SPAN |=>
		sys_resp && !sys_err && sys_rdata == 32'h0 && !pb.req)
		else $error("hole access not zero");
	pb_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		pb.req && !pb_ack |=> pb.req && $stable(pb.addr) && $stable(pb.wdata)) else $error("req dropped early");
	sel_onehot_a: assert property (@(posedge clk) disable iff (!rstn)
		pb.req |-> $onehot(pb.sel)) else $error("select not one-hot");
	decode_ir_a: assert property (@(posedge clk) disable iff (!rstn)
		sys_take && !sys_bad && sys_req.addr[31:16] == 16'h8003 && sys_req.addr[15:0] < REG_SPAN |=>
		pb.req && pb.sel == 9'h008) else $error("ir uart base misdecoded");
	width_low_a: assert property (@(posedge clk) disable iff (!rstn)
		pb.req && pb.sel[0] |-> pb.wdata[31:8] == 24'h0) else $error("usb write wider than 8 bits");
	no_pin_dma_a: assert property (@(posedge clk) disable iff (!rstn)
		dma_take && dma_req.unit == 4'h8 |=> dma_done && dma_err && !pb.req) else $error("pin dma not refused");
	display_off_a: assert property (@(posedge clk) disable iff (!rstn)
		sys_req.valid && sys_req.addr[31:16] == 16'hb010 |-> !sys_accept) else $error("display access claimed");
	uart_burst_a: assert property (@(posedge clk) disable iff (!rstn)
		dma_take && !dma_bad && dma_req.unit == 4'h1 |=> st_r.beats == 4'h4) else $error("uart burst not 4");
	read_low_a: assert property (@(posedge clk) disable iff (!rstn)
		sys_resp && st_r.unit == 4'h6 |-> sys_rdata[31:16] == 16'h0) else $error("codec read not low-justified");

	pio_cov: cover property (@(posedge clk) disable iff (!rstn) sys_take ##[1:20] sys_resp && !sys_err);
	dma_cov: cover property (@(posedge clk) disable iff (!rstn) dma_take ##[1:200] dma_done && !dma_err);
	bad_cov: cover property (@(posedge clk) disable iff (!rstn) sys_take && sys_bad);
	irq_cov: cover property (@(posedge clk) disable iff (!rstn) irq_pending[19] && irq_pending[18]);

endmodule // pbg_gateway

`default_nettype wire

// file: dv/pbg_pb_model.sv
// Purpose: behavioural peripheral units on the handshake bus
// Assumes: one word register per unit, ack delay set by the bench
// Notes:   read data is inverted garbage outside ack
`timescale 1ns/1ps
`default_nettype none

module pbg_pb_model (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire pbg_pkg::pbg_pb_out_type pb,
	input  wire logic [1:0]              delay,
	output logic                         pb_ack,
	output logic [31:0]                  pb_rdata
);
	logic [31:0] mem [9];
	logic [31:0] last_r;
	logic [1:0]  cnt_r;
	int          idx;

	// one-hot select to unit index
	always_comb begin
		idx = 0;
		for (int i = 0; i < 9; i++) begin
			if (pb.sel[i]) idx = i;
		end
	end

	// four-phase answer, ack held until req drops
	always @(posedge clk) begin
		if (!rstn) begin
			pb_ack <= 1'b0;
			cnt_r  <= 2'h0;
			last_r <= 32'h0;
		end else if (pb.req && !pb_ack) begin
			cnt_r <= cnt_r + 2'h1;
			if (cnt_r >= delay) begin
				pb_ack <= 1'b1;
				cnt_r  <= 2'h0;
				if (pb.write) mem[idx] <= pb.wdata;
				last_r <= mem[idx];
			end
		end else if (!pb.req) begin
			pb_ack <= 1'b0;
		end
	end

	// stale data never shows once released
	assign pb_rdata = pb_ack ? last_r : ~last_r;
endmodule // pbg_pb_model
`default_nettype wire

// file: dv/pbg_gateway_tb.sv
// Purpose: self-checking bench of the peripheral bus gateway
// Assumes: inputs driven at rising edge, outputs sampled at falling edge
// Notes:   partner model stands on the peripheral bus
`timescale 1ns/1ps
`default_nettype none

module pbg_gateway_tb;
	logic                     clk = 1'b0;
	logic                     rstn = 1'b0;
	pbg_pkg::pbg_sys_req_type sys_req = '0;
	pbg_pkg::pbg_dma_req_type dma_req = '0;
	pbg_pkg::pbg_irq_src_type irq_src = '0;
	logic [31:0]              dma_wdata = 32'h0;
	logic [31:0]              irq_mask = 32'h0;
	logic [1:0]               delay = 2'h0;
	logic                     sys_accept, sys_resp, sys_err, dma_accept, dma_data_take;
	logic                     dma_beat_done, dma_done, dma_err, pb_ack;
	logic [31:0]              sys_rdata, dma_rdata, pb_rdata, irq_pending, rd;
	pbg_pkg::pbg_pb_out_type  pb;
	logic                     er;
	int                       bad_count = 0;
	int                       check_count = 0;
	int                       req_cnt = 0;
	logic [15:0]              pb_addr_seen = 16'h0;

	pbg_gateway u_pbg_gateway (.clk(clk), .rstn(rstn), .sys_req(sys_req), .sys_accept(sys_accept),
		.sys_resp(sys_resp), .sys_err(sys_err), .sys_rdata(sys_rdata), .dma_req(dma_req),
		.dma_wdata(dma_wdata), .dma_accept(dma_accept), .dma_data_take(dma_data_take),
		.dma_beat_done(dma_beat_done), .dma_done(dma_done), .dma_err(dma_err), .dma_rdata(dma_rdata),
		.pb(pb), .pb_ack(pb_ack), .pb_rdata(pb_rdata), .irq_src(irq_src), .irq_mask(irq_mask),
		.irq_pending(irq_pending));
	pbg_pb_model u_pbg_pb_model (.clk(clk), .rstn(rstn), .pb(pb), .delay(delay), .pb_ack(pb_ack),
		.pb_rdata(pb_rdata));

	// clock and peripheral request counter
	initial forever #10 clk = ~clk;
	always @(posedge pb.req) begin
		req_cnt++;
		pb_addr_seen = pb.addr;
	end

	task automatic close_out();
		if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic timeout(input string nm);
		bad_count++;
		$display("ERROR %s expected pulse seen timeout", nm);
		close_out();
	endtask

	// one programmed access, valid held until the take edge
	task automatic sys_acc(input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] wd,
		input logic take, output logic [31:0] rdata, output logic err);
		logic took, done;
		took = 1'b0;
		done = 1'b0;
		rdata = 32'h0;
		err = 1'b0;
		@(posedge clk);
		sys_req <= '{1'b1, w, sz, a, wd};
		for (int i = 0; i < 8 && !took; i++) begin
			@(negedge clk);
			took = (sys_accept === 1'b1);
		end
		@(posedge clk);
		sys_req.valid <= 1'b0;
		check("sys_accept", {31'h0, take}, {31'h0, took});
		if (took) begin
			for (int i = 0; i < 40 && !done; i++) begin
				@(negedge clk);
				done = (sys_resp === 1'b1);
			end
			if (!done) timeout("sys_resp");
			rdata = sys_rdata;
			err = sys_err;
		end
	endtask

	// one DMA burst, beats counted up to the done pulse
	task automatic dma_run(input logic w, input logic [3:0] u, input logic [15:0] off, input int nb,
		input logic xerr);
		logic took, fin;
		int   beats;
		int   takes;
		took = 1'b0;
		fin = 1'b0;
		beats = 0;
		takes = 0;
		@(posedge clk);
		dma_req <= '{1'b1, w, u, off};
		dma_wdata <= 32'h00005a5a;
		for (int i = 0; i < 8 && !took; i++) begin
			@(negedge clk);
			if (dma_data_take === 1'b1) takes++;
			took = (dma_accept === 1'b1);
		end
		@(posedge clk);
		dma_req.valid <= 1'b0;
		if (!took) timeout("dma_accept");
		for (int i = 0; i < 200 && !fin; i++) begin
			@(negedge clk);
			if (dma_beat_done === 1'b1) beats++;
			if (dma_data_take === 1'b1) takes++;
			fin = (dma_done === 1'b1);
		end
		if (!fin) timeout("dma_done");
		check("dma_beats", 32'(nb), 32'(beats));
		check("dma_takes", 32'(nb), 32'(takes));
		check("dma_err", {31'h0, xerr}, {31'h0, dma_err});
	endtask

	// every unit region written, read back and probed past its registers
	task automatic t_regs();
		logic [15:0] hi;
		logic [31:0] exp;
		logic [31:0] wd;
		for (int u = 0; u < 9; u++) begin
			hi = (u < 8) ? 16'h8000 + 16'(u) : 16'h9006;
			wd = 32'h12345670 | 32'(u);
			exp = wd & ((u < 6) ? 32'h000000ff : (u < 8) ? 32'h0000ffff : 32'hffffffff);
			delay <= 2'(u);
			sys_acc(1'b1, 2'h2, {hi, 16'h0010}, wd, 1'b1, rd, er);
			check("pb_addr", 32'h00000010, {16'h0, pb_addr_seen});
			sys_acc(1'b0, 2'h2, {hi, 16'h0010}, 32'h0, 1'b1, rd, er);
			check("reg_rdata", exp, rd);
			check("reg_err", 32'h0, {31'h0, er});
			sys_acc(1'b1, 2'h2, {hi, 16'hfffc}, 32'hffffffff, 1'b1, rd, er);
			sys_acc(1'b0, 2'h2, {hi, 16'hfffc}, 32'h0, 1'b1, rd, er);
			check("hole_rdata", 32'h0, rd);
			sys_acc(1'b0, 2'h2, {hi, 16'h0010}, 32'h0, 1'b1, rd, er);
			check("hole_write", exp, rd);
		end
		// every unit read again: no unit shares a register with another
		for (int u = 0; u < 9; u++) begin
			hi = (u < 8) ? 16'h8000 + 16'(u) : 16'h9006;
			wd = 32'h12345670 | 32'(u);
			exp = wd & ((u < 6) ? 32'h000000ff : (u < 8) ? 32'h0000ffff : 32'hffffffff);
			sys_acc(1'b0, 2'h2, {hi, 16'h0010}, 32'h0, 1'b1, rd, er);
			check("reg_alone", exp, rd);
		end
	endtask

	// programmed access and DMA offered together, programmed taken first
	task automatic t_both();
		logic took;
		took = 1'b0;
		@(posedge clk);
		dma_req <= '{1'b1, 1'b1, 4'h1, 16'h0010};
		sys_req <= '{1'b1, 1'b0, 2'h2, 32'h80010010, 32'h0};
		@(negedge clk);
		check("both_sys", 32'h1, {31'h0, sys_accept});
		check("both_dma", 32'h0, {31'h0, dma_accept});
		@(posedge clk);
		sys_req.valid <= 1'b0;
		for (int i = 0; i < 40 && !took; i++) begin
			@(negedge clk);
			took = (dma_accept === 1'b1);
		end
		@(posedge clk);
		dma_req.valid <= 1'b0;
		if (!took) timeout("dma_accept");
		for (int i = 0; i < 200 && dma_done !== 1'b1; i++) @(negedge clk);
		if (dma_done !== 1'b1) timeout("dma_done");
		check("both_dma_err", 32'h0, {31'h0, dma_err});
	endtask

	// narrow, misaligned and foreign accesses
	task automatic t_refuse();
		int n;
		n = req_cnt;
		for (int s = 0; s < 4; s++) begin
			if (s != 2) sys_acc(1'b1, 2'(s), 32'h80050010, 32'h0, 1'b1, rd, er);
			if (s != 2) check("narrow_err", 32'h1, {31'h0, er});
		end
		sys_acc(1'b0, 2'h2, 32'h80060012, 32'h0, 1'b1, rd, er);
		check("misalign_err", 32'h1, {31'h0, er});
		check("refuse_pb", 32'(n), 32'(req_cnt));
		sys_acc(1'b0, 2'h2, 32'hb0100000, 32'h0, 1'b0, rd, er);
		sys_acc(1'b0, 2'h2, 32'h80080000, 32'h0, 1'b0, rd, er);
		sys_acc(1'b0, 2'h2, 32'h90050000, 32'h0, 1'b0, rd, er);
	endtask

	// burst length per unit, refusals and read back
	task automatic t_dma();
		int tab[10] = '{8, 4, 0, 4, 8, 4, 4, 4, 0, 0};
		for (int u = 0; u < 10; u++) begin
			delay <= 2'(u);
			dma_run(1'b1, 4'(u), 16'h0010, tab[u], tab[u] == 0);
		end
		dma_run(1'b0, 4'h0, 16'h0010, 8, 1'b0);
		check("dma_rdata", 32'h0000005a, dma_rdata);
		dma_run(1'b0, 4'h6, 16'h0012, 0, 1'b1);
		dma_run(1'b0, 4'h7, 16'h0100, 0, 1'b1);
	endtask

	// each line alone, then masked off
	task automatic t_irq();
		int bt[8] = '{12, 13, 15, 16, 16, 17, 18, 19};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			irq_mask <= 32'hffffffff;
			irq_src <= 8'(8'h80 >> i);
			repeat (2) @(posedge clk);
			@(negedge clk);
			check("irq_pending", 32'h1 << bt[i], irq_pending);
			@(posedge clk);
			irq_mask <= ~(32'h1 << bt[i]);
			repeat (2) @(posedge clk);
			@(negedge clk);
			check("irq_masked", 32'h0, irq_pending);
		end
		@(posedge clk);
		irq_mask <= 32'hffffffff;
		irq_src <= 8'h03;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("irq_both", 32'h000c0000, irq_pending);
		@(posedge clk);
		irq_src <= '0;
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_refuse();
		t_dma();
		t_both();
		t_irq();
		close_out();
	end
endmodule // pbg_gateway_tb
`default_nettype wire
